/* rtl/smram_access_control.sv */
// window control register and request steering for the compatible smm window
// assumes request and config ports come from logic on core_clk_in
// one update per edge; neither port inserts wait states
`timescale 1ns/100ps
module smram_access_control (
	input  wire logic                     core_clk_in,   // 10 MHz clock
	input  wire logic                     rst_n_in,      // full reset, async, low
	input  wire logic                     cfg_wr_in,     // config write strobe
	input  wire logic [7:0]               cfg_wdata_in,  // config write data
	output logic      [7:0]               cfg_rdata_out, // register readback
	input  wire logic                     req_valid_in,  // request strobe
	input  wire smm_window_pkg::mem_req_s req_in,        // request fields
	output smm_window_pkg::route_e        route_out,     // routing decision
	output logic      [31:0]              route_addr_out,// address passed on
	output logic                          ext_enable_out // extended function allowed
);
	////////////////////////////////////////////////////////////////////////
	logic open_q, open_d, closed_q, closed_d, lock_q, lock_d, glob_q, glob_d;

	// register update; once locked only the closed bit stays writable
	always_comb begin
		open_d   = open_q;
		closed_d = closed_q;
		lock_d   = lock_q;
		glob_d   = glob_q;
		if (cfg_wr_in) begin
			closed_d = cfg_wdata_in[smm_window_pkg::BIT_CLOSED];
			if (!lock_q) begin
				glob_d = cfg_wdata_in[smm_window_pkg::BIT_GLOBAL];
				lock_d = cfg_wdata_in[smm_window_pkg::BIT_LOCK];
				open_d = cfg_wdata_in[smm_window_pkg::BIT_OPEN] &
				         !cfg_wdata_in[smm_window_pkg::BIT_LOCK];
			end
		end
	end

	// lock has no software clear path; only reset drops it
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			open_q   <= 1'b0;
			closed_q <= 1'b0;
			lock_q   <= 1'b0;
			glob_q   <= 1'b0;
		end else begin
			open_q   <= open_d;
			closed_q <= closed_d;
			lock_q   <= lock_d;
			glob_q   <= glob_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic in_window(input logic [31:0] a);
		in_window = (a >= smm_window_pkg::WINDOW_BASE) &&
		            (a <= smm_window_pkg::WINDOW_LAST);
	endfunction : in_window

	// the window compare and the carried address assume one address width
	if (smm_window_pkg::ADDR_W != $bits(route_addr_out)) begin : g_addr_w_check
		$error("request address width does not match the routed address port");
	end

	smm_window_pkg::route_e route_d;
	logic [7:0]             rdata_d;
	logic                   ext_d;
	logic                   visible;

	// steering: controls only count with global enable set
	always_comb begin
		visible = 1'b0;
		route_d = smm_window_pkg::ROUTE_NONE;
		if (glob_q) begin
			if (open_q && !lock_q)
				visible = 1'b1;
			if (req_in.smm)
				visible = 1'b1;
		end
		if (req_valid_in) begin
			if (!in_window(req_in.addr))
				route_d = smm_window_pkg::ROUTE_HUB;
			else if (glob_q && closed_q && !req_in.code && !(open_q && !lock_q))
				route_d = smm_window_pkg::ROUTE_BLOCKED;
			else if (visible)
				route_d = smm_window_pkg::ROUTE_DRAM;
			else
				route_d = smm_window_pkg::ROUTE_HUB;
		end
		ext_d   = glob_q;
		rdata_d = {1'b0, open_q, closed_q, lock_q, glob_q,
		           smm_window_pkg::BASE_SEGMENT};
	end

	// every output is a flop so downstream timing never sees the decode
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			route_out      <= smm_window_pkg::ROUTE_NONE;
			route_addr_out <= '0;
			ext_enable_out <= 1'b0;
			cfg_rdata_out  <= smm_window_pkg::CTRL_RESET;
		end else begin
			route_out      <= route_d;
			route_addr_out <= req_in.addr;
			ext_enable_out <= ext_d;
			cfg_rdata_out  <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock never falls while reset stays away
	property p_lock_sticky;
		@(posedge core_clk_in) disable iff (!rst_n_in) lock_q |=> lock_q;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");

	// open can never stand beside lock
	property p_lock_clears_open;
		@(posedge core_clk_in) disable iff (!rst_n_in) lock_q |-> !open_q;
	endproperty
	a_lock_clears_open: assert property (p_lock_clears_open) else $error("open with lock");

	// global enable is frozen once locked
	property p_glob_frozen;
		@(posedge core_clk_in) disable iff (!rst_n_in) lock_q |=> glob_q == $past(glob_q);
	endproperty
	a_glob_frozen: assert property (p_glob_frozen) else $error("enable moved");

	// without global enable every request goes to the hub
	property p_no_glob_hub;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			req_valid_in && !glob_q |=> route_out == smm_window_pkg::ROUTE_HUB;
	endproperty
	a_no_glob_hub: assert property (p_no_glob_hub) else $error("dram without enable");

	// an smm request in the window reaches dram while not closed
	property p_smm_dram;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			req_valid_in && glob_q && !closed_q && req_in.smm && in_window(req_in.addr)
			|=> route_out == smm_window_pkg::ROUTE_DRAM;
	endproperty
	a_smm_dram: assert property (p_smm_dram) else $error("smm not mapped");

	// locked and closed: data references are blocked
	property p_closed_data;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			req_valid_in && glob_q && closed_q && lock_q && !req_in.code
			&& in_window(req_in.addr) |=> route_out == smm_window_pkg::ROUTE_BLOCKED;
	endproperty
	a_closed_data: assert property (p_closed_data) else $error("data not blocked");

	// closed still passes smm code fetches
	property p_closed_code;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			req_valid_in && glob_q && closed_q && req_in.smm && req_in.code
			&& in_window(req_in.addr) |=> route_out == smm_window_pkg::ROUTE_DRAM;
	endproperty
	a_closed_code: assert property (p_closed_code) else $error("code blocked");

	// readback always shows the fixed segment and a clear reserved bit
	property p_base_seg;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			cfg_rdata_out[$bits(smm_window_pkg::BASE_SEGMENT)-1:0] == smm_window_pkg::BASE_SEGMENT
			&& !cfg_rdata_out[$left(cfg_rdata_out)];
	endproperty
	a_base_seg: assert property (p_base_seg) else $error("base segment wrong");

	// a write that sets lock while still unlocked
	sequence s_lock_write;
		cfg_wr_in && cfg_wdata_in[smm_window_pkg::BIT_LOCK] && !lock_q;
	endsequence

	// lock lands at the next edge with open cleared, readback one edge later
	property p_lock_takes;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			s_lock_write |=> lock_q && !open_q ##1 cfg_rdata_out[smm_window_pkg::BIT_LOCK];
	endproperty
	a_lock_takes: assert property (p_lock_takes) else $error("lock write lost");

	// closed stays writable under lock; with closed and global enable set in-window data references go to blocked, not to the hub, unless open is set without lock
	property p_closed_writable;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			lock_q && cfg_wr_in && cfg_wdata_in[smm_window_pkg::BIT_CLOSED] |=> closed_q;
	endproperty
	a_closed_writable: assert property (p_closed_writable) else $error("closed write lost");

	// open and unlocked: any in-window request reaches dram
	property p_open_visible;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			req_valid_in && glob_q && open_q && !lock_q && in_window(req_in.addr)
			|=> route_out == smm_window_pkg::ROUTE_DRAM;
	endproperty
	a_open_visible: assert property (p_open_visible) else $error("open not visible");

	// an in-window data request while closed and not open
	sequence s_closed_data_req;
		req_valid_in && glob_q && closed_q && !open_q && !req_in.code
		&& in_window(req_in.addr);
	endsequence

	// blocked whether or not lock is set
	property p_closed_unlk;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			s_closed_data_req |=> route_out == smm_window_pkg::ROUTE_BLOCKED;
	endproperty
	a_closed_unlk: assert property (p_closed_unlk) else $error("data not blocked");

	// outside the window the hub always takes the request
	property p_hub_outside;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			req_valid_in && !in_window(req_in.addr)
			|=> route_out == smm_window_pkg::ROUTE_HUB;
	endproperty
	a_hub_outside: assert property (p_hub_outside) else $error("outside not forwarded");

	// the address is carried through unchanged, no remap
	property p_route_addr;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			req_valid_in |=> route_addr_out == $past(req_in.addr);
	endproperty
	a_route_addr: assert property (p_route_addr) else $error("address changed");

	// extended permission tracks global enable one edge later
	property p_ext_follows;
		@(posedge core_clk_in) disable iff (!rst_n_in)
			1'b1 |=> ext_enable_out == $past(glob_q);
	endproperty
	a_ext_follows: assert property (p_ext_follows) else $error("extended enable wrong");
endmodule : smram_access_control

/* rtl/smm_window_pkg.sv */
// constants and carriers for the compatible smm window access control
// assumes a configuration write port and a processor request port on one clock
package smm_window_pkg;
	localparam int          ADDR_W          = 32;
	localparam logic [31:0] WINDOW_BASE     = 32'h000A_0000;
	localparam logic [31:0] WINDOW_LAST     = 32'h000B_FFFF;
	localparam int          BIT_OPEN        = 6;
	localparam int          BIT_CLOSED      = 5;
	localparam int          BIT_LOCK        = 4;
	localparam int          BIT_GLOBAL      = 3;
	localparam logic [2:0]  BASE_SEGMENT    = 3'h2;
	localparam logic [7:0]  CTRL_RESET      = 8'h02;

	// one processor memory request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              smm;   // issued in system-management mode
		logic              code;  // instruction fetch
	} mem_req_s;

	// where a request goes
	typedef enum logic [1:0] {
		ROUTE_NONE,
		ROUTE_DRAM,
		ROUTE_HUB,
		ROUTE_BLOCKED
	} route_e;
endpackage : smm_window_pkg

/* tb/host_req_model.sv */
// processor side model: issues one memory request per call, smm and code tagged
// assumes the bench calls issue from a single process on the core clock
`timescale 1ns/100ps
module host_req_model (
	input  wire logic                     clk_in,    // core clock
	output logic                          valid_out, // request strobe
	output smm_window_pkg::mem_req_s      req_out    // request fields
);
	initial begin
		valid_out = 1'b0;
		req_out   = '0;
	end
	////////////////////////////////////////////////////////////////////////////
	// fields are inverted after the strobe so a stale value can never pass as a hit
	task automatic issue(input logic [31:0] a, input logic s, input logic c);
		@(posedge clk_in);
		valid_out <= 1'b1;
		req_out   <= '{addr: a, smm: s, code: c};
		@(posedge clk_in);
		valid_out <= 1'b0;
		req_out   <= '{addr: ~a, smm: ~s, code: ~c};
	endtask : issue
endmodule : host_req_model

/* tb/tb.sv */
// self-checking bench for the smm window control register and request steering
// assumes the design asserts its own rules internally
`timescale 1ns/100ps
module tb;
	logic                     core_clk_in = 1'b0;
	logic                     rst_n_in = 1'b0;
	logic                     cfg_wr_in = 1'b0;
	logic [7:0]               cfg_wdata_in = 8'h00;
	logic [7:0]               cfg_rdata_out;
	logic                     req_valid_in;
	smm_window_pkg::mem_req_s req_in;
	smm_window_pkg::route_e   route_out;
	logic [31:0]              route_addr_out;
	logic                     ext_enable_out;
	int                       error_cnt = 0;
	int                       samples_checked = 0;
	int                       cycles = 0;
	always #50 core_clk_in = ~core_clk_in;
	smram_access_control uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
		.req_valid_in(req_valid_in), .req_in(req_in), .route_out(route_out),
		.route_addr_out(route_addr_out), .ext_enable_out(ext_enable_out));
	host_req_model u_host (.clk_in(core_clk_in), .valid_out(req_valid_in), .req_out(req_in));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk_val
	task automatic chk_route(input smm_window_pkg::route_e e);
		samples_checked++;
		if (route_out !== e) begin
			error_cnt++;
			$display("unexpected route expected %0d seen %0d", e, route_out);
		end
	endtask : chk_route
	// write then wait one more edge so readback has caught up
	task automatic wr(input logic [7:0] d);
		@(posedge core_clk_in);
		cfg_wr_in    <= 1'b1;
		cfg_wdata_in <= d;
		@(posedge core_clk_in);
		cfg_wr_in    <= 1'b0;
		cfg_wdata_in <= ~d;
		@(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask : wr
	task automatic req(input logic [31:0] a, input logic s, input logic c,
		input smm_window_pkg::route_e e);
		u_host.issue(a, s, c);
		@(negedge core_clk_in);
		chk_route(e);
		chk_val("route_addr", a, route_addr_out);
		@(negedge core_clk_in);
		chk_route(smm_window_pkg::ROUTE_NONE);
	endtask : req
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// a hang costs a mismatch; the sequence needs well under 300 cycles
	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			error_cnt++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(negedge core_clk_in);
		chk_val("ctrl", 8'h02, cfg_rdata_out);
		chk_val("ext", 0, ext_enable_out);
		chk_route(smm_window_pkg::ROUTE_NONE);
		wr(8'h40);
		req(32'h000A_0000, 1'b0, 1'b0, smm_window_pkg::ROUTE_HUB);
		req(32'h000A_0000, 1'b1, 1'b0, smm_window_pkg::ROUTE_HUB);
		wr(8'h08);
		chk_val("ctrl", 8'h0A, cfg_rdata_out);
		chk_val("ext", 1, ext_enable_out);
		req(32'h000A_0000, 1'b1, 1'b0, smm_window_pkg::ROUTE_DRAM);
		req(32'h000B_FFFF, 1'b1, 1'b0, smm_window_pkg::ROUTE_DRAM);
		req(32'h000C_0000, 1'b1, 1'b0, smm_window_pkg::ROUTE_HUB);
		req(32'h000A_0000, 1'b0, 1'b0, smm_window_pkg::ROUTE_HUB);
		wr(8'h48);
		req(32'h000B_0000, 1'b0, 1'b0, smm_window_pkg::ROUTE_DRAM);
		wr(8'h28);
		req(32'h000A_0000, 1'b1, 1'b0, smm_window_pkg::ROUTE_BLOCKED);
		req(32'h000A_0000, 1'b1, 1'b1, smm_window_pkg::ROUTE_DRAM);
		req(32'h000C_0000, 1'b1, 1'b0, smm_window_pkg::ROUTE_HUB);
		wr(8'h18);
		chk_val("ctrl", 8'h1A, cfg_rdata_out);
		req(32'h000A_0000, 1'b0, 1'b0, smm_window_pkg::ROUTE_HUB);
		wr(8'h20);
		chk_val("ctrl", 8'h3A, cfg_rdata_out);
		chk_val("ext", 1, ext_enable_out);
		req(32'h000A_0000, 1'b1, 1'b0, smm_window_pkg::ROUTE_BLOCKED);
		req(32'h000A_0000, 1'b0, 1'b1, smm_window_pkg::ROUTE_HUB);
		wr(8'h40);
		chk_val("ctrl", 8'h1A, cfg_rdata_out);
		@(posedge core_clk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(negedge core_clk_in);
		chk_val("ctrl", 8'h02, cfg_rdata_out);
		chk_val("ext", 0, ext_enable_out);
		chk_val("route_addr", 0, route_addr_out);
		chk_route(smm_window_pkg::ROUTE_NONE);
		end_of_test();
	end
endmodule : tb
